/* omx_decode.sv */
// Purpose: classify an instruction word into one of the handled operations
// Assumes: purely combinational, same clock domain as caller
// Notes: words that match none give the none code
`timescale 1ns/100ps
module omx_decode
    import omx_pkg::*;
(
    input wire logic [11:0] insn_in,
    output omx_op_e op_out
);
    always_comb begin
        if ((insn_in & OMX_LIT_MASK) == OMX_OR_LIT_PAT) begin
            op_out = OMX_OP_OR_LIT;
        end else if ((insn_in & OMX_LIT_MASK) == OMX_LOAD_LIT_PAT) begin
            op_out = OMX_OP_LOAD_LIT;
        end else if ((insn_in & OMX_REG_MASK) == OMX_OR_REG_PAT) begin
            op_out = OMX_OP_OR_REG;
        end else if ((insn_in & OMX_REG_MASK) == OMX_MOVE_REG_PAT) begin
            op_out = OMX_OP_MOVE_REG;
        end else begin
            op_out = OMX_OP_NONE;
        end
    end
endmodule

/* omx_exec.sv */
// Purpose: execute or-literal, or-register, move-register and load-literal
// Assumes: register file read data is combinational from the address output
// Notes: one instruction per clock, results registered
`timescale 1ns/100ps
module omx_exec
    import omx_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic insn_valid_in,
    input wire logic [11:0] insn_in,
    input wire logic [7:0] file_rdata_in,
    output logic [4:0] file_addr_out,
    output logic [7:0] file_wdata_out,
    output logic file_we_out,
    output logic [7:0] acc_out,
    output logic zero_flag_out
);
    ////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] acc;
        logic zero;
        logic [4:0] waddr;
        logic [7:0] wdata;
        logic we;
    } omx_state_s;

    omx_state_s st_q;
    omx_state_s st_d;
    omx_op_e op;
    logic dest;
    logic [7:0] lit;
    logic [7:0] res;

    omx_decode u_decode (
        .insn_in(insn_in),
        .op_out(op)
    );

    assign dest = insn_in[OMX_DEST_BIT];
    assign lit = insn_in[7:0];
    // address is combinational so the read lands in the same cycle
    assign file_addr_out = insn_in[4:0];

    ////////////////////////////////////////////////////////////////
    // zero test shared by the or-literal, or-register and move paths
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // pattern checks for the assertions, apart from the decoder's priority chain
    function automatic logic is_or_lit(input logic [11:0] w);
        return (w & OMX_LIT_MASK) == OMX_OR_LIT_PAT;
    endfunction

    function automatic logic is_load_lit(input logic [11:0] w);
        return (w & OMX_LIT_MASK) == OMX_LOAD_LIT_PAT;
    endfunction

    function automatic logic is_or_reg(input logic [11:0] w);
        return (w & OMX_REG_MASK) == OMX_OR_REG_PAT;
    endfunction

    function automatic logic is_move_reg(input logic [11:0] w);
        return (w & OMX_REG_MASK) == OMX_MOVE_REG_PAT;
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.we = 1'b0;
        res = 8'h00;
        if (insn_valid_in) begin
            case (op)
                OMX_OP_OR_LIT: begin
                    res = st_q.acc | lit;
                    st_d.acc = res;
                    st_d.zero = is_zero(res);
                end
                OMX_OP_OR_REG: begin
                    res = st_q.acc | file_rdata_in;
                    st_d.zero = is_zero(res);
                    if (dest) begin
                        st_d.we = 1'b1;
                        st_d.waddr = insn_in[4:0];
                        st_d.wdata = res;
                    end else begin
                        st_d.acc = res;
                    end
                end
                OMX_OP_MOVE_REG: begin
                    res = file_rdata_in;
                    st_d.zero = is_zero(res);
                    if (dest) begin
                        st_d.we = 1'b1;
                        st_d.waddr = insn_in[4:0];
                        st_d.wdata = res;
                    end else begin
                        st_d.acc = res;
                    end
                end
                OMX_OP_LOAD_LIT: begin
                    st_d.acc = lit;
                end
                default: begin
                    st_d.we = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_q <= '{
                acc: OMX_ACC_RST,
                zero: OMX_ZERO_RST,
                waddr: 5'h00,
                wdata: 8'h00,
                we: 1'b0
            };
        end else begin
            st_q <= st_d;
        end
    end

    // write port lags one cycle; a write-back of the same register is harmless
    assign file_we_out = st_q.we;
    assign file_wdata_out = st_q.wdata;
    assign acc_out = st_q.acc;
    assign zero_flag_out = st_q.zero;

    ////////////////////////////////////////////////////////////////
    // or literal: accumulator only, zero follows the result
    AST_OR_LIT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_lit(insn_in) |=>
        acc_out == ($past(acc_out) | $past(insn_in[7:0])) && zero_flag_out == is_zero(acc_out))
        else $error("or literal result wrong");

    AST_OR_LIT_NO_WR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_lit(insn_in) |=> !file_we_out)
        else $error("or literal wrote the file");

    ////////////////////////////////////////////////////////////////
    AST_OR_REG_Z: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_reg(insn_in) |=>
        zero_flag_out == is_zero($past(acc_out) | $past(file_rdata_in)))
        else $error("or register zero flag wrong");

    AST_OR_REG_DEST: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_reg(insn_in) && insn_in[OMX_DEST_BIT] |=>
        file_we_out && acc_out == $past(acc_out)
        && file_wdata_out == ($past(acc_out) | $past(file_rdata_in)))
        else $error("or register to file wrong");

    AST_OR_REG_ACC: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_reg(insn_in) && !insn_in[OMX_DEST_BIT] |=>
        !file_we_out && acc_out == ($past(acc_out) | $past(file_rdata_in)))
        else $error("or register to acc wrong");

    AST_OR_REG_ROW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_or_reg(insn_in) && insn_in[OMX_DEST_BIT] |=>
        st_q.waddr == $past(insn_in[4:0]))
        else $error("or register wrote the wrong row");

    ////////////////////////////////////////////////////////////////
    AST_MOVE_ACC: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_move_reg(insn_in) && !insn_in[OMX_DEST_BIT] |=>
        acc_out == $past(file_rdata_in) && !file_we_out)
        else $error("move to acc wrong");

    AST_MOVE_FILE: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_move_reg(insn_in) && insn_in[OMX_DEST_BIT] |=>
        file_we_out && file_wdata_out == $past(file_rdata_in)
        && acc_out == $past(acc_out))
        else $error("move to file wrong");

    AST_MOVE_ROW: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_move_reg(insn_in) && insn_in[OMX_DEST_BIT] |=>
        st_q.waddr == $past(insn_in[4:0]))
        else $error("move wrote the wrong row");

    AST_MOVE_Z: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_move_reg(insn_in) |=>
        zero_flag_out == is_zero($past(file_rdata_in)))
        else $error("move zero flag wrong");

    ////////////////////////////////////////////////////////////////
    AST_LOAD_LIT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && is_load_lit(insn_in) |=>
        acc_out == $past(insn_in[7:0]) && $stable(zero_flag_out) && !file_we_out)
        else $error("load literal wrong");

    // a one-edge reset is legal, so the edge after it is excused
    AST_ZERO_HELD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !$stable(zero_flag_out) |-> $past(sys_rst_in) || $past(insn_valid_in)
        && (is_or_lit($past(insn_in)) || is_or_reg($past(insn_in))
        || is_move_reg($past(insn_in))))
        else $error("zero flag changed without a flag-setting instruction");

    AST_ACC_HELD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !$stable(acc_out) |-> $past(sys_rst_in) || $past(insn_valid_in)
        && !((is_or_reg($past(insn_in)) || is_move_reg($past(insn_in)))
        && $past(insn_in[OMX_DEST_BIT])))
        else $error("accumulator changed without an accumulator write");

    AST_IDLE_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !insn_valid_in |=> $stable(acc_out) && $stable(zero_flag_out) && !file_we_out)
        else $error("idle cycle changed state");

    AST_REFUSED_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        insn_valid_in && !is_or_lit(insn_in) && !is_load_lit(insn_in) && !is_or_reg(insn_in)
        && !is_move_reg(insn_in) |=>
        $stable(acc_out) && $stable(zero_flag_out) && !file_we_out)
        else $error("refused word changed state");

    AST_RESET_VALUES: assert property (@(posedge ref_clk_in)
        sys_rst_in |=> acc_out == OMX_ACC_RST && zero_flag_out == OMX_ZERO_RST && !file_we_out)
        else $error("reset values wrong");
endmodule

/* omx_file_model.sv */
// Purpose: register file model beside the execute block
// Assumes: read is combinational, a write lands at the edge of the pulse
// Notes: write row is the address seen one edge earlier
`timescale 1ns/100ps
module omx_file_model (
    input wire logic clk_in,
    input wire logic [4:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic we_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [32];
    logic [4:0] addr_q;
    assign rdata_out = mem[addr_in];
    // plain always: the bench preloads rows directly
    always @(posedge clk_in) begin
        addr_q <= addr_in;
        if (we_in) begin
            mem[addr_q] <= wdata_in;
        end
    end
endmodule

/* omx_pkg.sv */
// Purpose: shared constants for the or/move instruction execute block
// Assumes: 12-bit instruction words, 8-bit data, 5-bit file addresses
// Notes: opcode patterns are matched under masks
package omx_pkg;
    localparam int OMX_DATA_W = 8;
    localparam int OMX_ADDR_W = 5;
    localparam int OMX_INSN_W = 12;
    localparam logic [11:0] OMX_LIT_MASK = 12'hf00;
    localparam logic [11:0] OMX_REG_MASK = 12'hfc0;
    localparam logic [11:0] OMX_OR_LIT_PAT = 12'hd00;
    localparam logic [11:0] OMX_LOAD_LIT_PAT = 12'hc00;
    localparam logic [11:0] OMX_OR_REG_PAT = 12'h100;
    localparam logic [11:0] OMX_MOVE_REG_PAT = 12'h200;
    localparam int OMX_DEST_BIT = 5;
    localparam logic [7:0] OMX_ACC_RST = 8'h00;
    localparam logic OMX_ZERO_RST = 1'b0;

    typedef enum logic [2:0] {
        OMX_OP_NONE = 3'b000,
        OMX_OP_OR_LIT = 3'b001,
        OMX_OP_OR_REG = 3'b010,
        OMX_OP_MOVE_REG = 3'b011,
        OMX_OP_LOAD_LIT = 3'b100
    } omx_op_e;
endpackage

/* test_or_move_instruction_exec.sv */
// Purpose: self-checking bench for the or/move execute block
// Assumes: results show one edge after the instruction is taken
// Notes: inputs change at the falling edge
`timescale 1ns/100ps
module test_or_move_instruction_exec;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic insn_valid_in = 1'b0;
    logic [11:0] insn_in = 12'h000;
    logic [7:0] file_rdata_in, file_wdata_out, acc_out;
    logic [4:0] file_addr_out;
    logic file_we_out, zero_flag_out;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #2 ref_clk_in = ~ref_clk_in;
    omx_exec dut_u (.ref_clk_in, .sys_rst_in, .insn_valid_in, .insn_in, .file_rdata_in,
        .file_addr_out, .file_wdata_out, .file_we_out, .acc_out, .zero_flag_out);
    omx_file_model fm_u (.clk_in(ref_clk_in), .addr_in(file_addr_out),
        .wdata_in(file_wdata_out), .we_in(file_we_out), .rdata_out(file_rdata_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one word per call; word and valid hold their values until the next call drives them at the falling edge
    task automatic run(input logic [11:0] w, input logic v);
        @(negedge ref_clk_in);
        insn_in <= w;
        insn_valid_in <= v;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_literals();
        run(12'hc9a, 1); run(12'hd35, 1);
        chk("acc", 8'hbf, acc_out);
        chk("zero", 8'h00, {7'h0, zero_flag_out});
        run(12'hc00, 1); run(12'hd00, 1);
        chk("zero", 8'h01, {7'h0, zero_flag_out});
        run(12'hc5a, 1);
        chk("acc", 8'h5a, acc_out);
        chk("zero", 8'h01, {7'h0, zero_flag_out});
        run(12'h000, 0);
        $display("literals done");
    endtask
    task automatic t_or_reg();
        fm_u.mem[16] = 8'h13;
        run(12'hc91, 1); run(12'h110, 1);
        chk("acc", 8'h93, acc_out);
        chk("we", 8'h00, {7'h0, file_we_out});
        run(12'h000, 0);
        chk("file", 8'h13, fm_u.mem[16]);
        run(12'hc80, 1); run(12'h130, 1);
        chk("we", 8'h01, {7'h0, file_we_out});
        chk("wdata", 8'h93, file_wdata_out);
        chk("addr", 8'h10, {3'h0, file_addr_out});
        chk("acc", 8'h80, acc_out);
        run(12'h000, 0);
        chk("file", 8'h93, fm_u.mem[16]);
        $display("or register done");
    endtask
    task automatic t_move();
        fm_u.mem[3] = 8'h00;
        fm_u.mem[4] = 8'h7e;
        run(12'hc11, 1); run(12'h203, 1);
        chk("acc", 8'h00, acc_out);
        chk("zero", 8'h01, {7'h0, zero_flag_out});
        run(12'h224, 1);
        chk("wdata", 8'h7e, file_wdata_out);
        chk("we", 8'h01, {7'h0, file_we_out});
        chk("acc", 8'h00, acc_out);
        chk("zero", 8'h00, {7'h0, zero_flag_out});
        run(12'h000, 0);
        chk("file", 8'h7e, fm_u.mem[4]);
        chk("file", 8'h00, fm_u.mem[3]);
        $display("move done");
    endtask
    task automatic t_refuse();
        run(12'hc44, 1); run(12'hd0f, 0); run(12'he0f, 1);
        chk("acc", 8'h44, acc_out);
        chk("we", 8'h00, {7'h0, file_we_out});
        run(12'h000, 0);
        $display("refuse done");
    endtask
    // reset lands over a valid load, and the word at release is taken at once
    task automatic t_reset();
        run(12'hc00, 1); run(12'hd00, 1); run(12'hc77, 1);
        @(negedge ref_clk_in);
        sys_rst_in <= 1'b1;
        insn_in <= 12'hcff;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("acc", 8'h00, acc_out);
        chk("zero", 8'h00, {7'h0, zero_flag_out});
        chk("we", 8'h00, {7'h0, file_we_out});
        @(negedge ref_clk_in);
        sys_rst_in <= 1'b0;
        insn_in <= 12'hd12;
        @(posedge ref_clk_in);
        #1;
        chk("acc", 8'h12, acc_out);
        run(12'h000, 0);
        $display("reset done");
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 500) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        t_literals(); t_or_reg(); t_move(); t_refuse(); t_reset();
        wrap_up();
    end
endmodule
